// ===== tepu_cfg.svh
`ifndef TEPU_CFG_SVH
`define TEPU_CFG_SVH
// Register byte addresses
`define TEPU_ADDR_CTRL 4'h0
`define TEPU_ADDR_COUNT 4'h4
`define TEPU_ADDR_DUTYB 4'h8
`define TEPU_ADDR_DUTYC 4'hc
// Control field positions (shared control byte)
`define TEPU_MODE_HI 7
`define TEPU_MODE_LO 6
`define TEPU_RUN_BIT 4
`define TEPU_EDGE_BIT 3
`define TEPU_DIV_HI 4
`define TEPU_DIV_LO 2
`define TEPU_RES_BIT 1
`define TEPU_EN_BIT 0
// Status bits in the byte just above the control byte of the control word
`define TEPU_OVF_BIT 8
`define TEPU_WAKE_BIT 9
// Reset values
`define TEPU_CTRL_RST 8'h00
`define TEPU_DUTY_RST 8'h00
// Mode encodings
`define TEPU_MODE_PWM 2'h0
`define TEPU_MODE_EVT 2'h1
`define TEPU_MODE_TMR 2'h2
`define TEPU_MODE_PWD 2'h3
// AXI response codes
`define TEPU_RESP_OKAY 2'h0
`define TEPU_RESP_SLVERR 2'h2
`endif

// ===== tepu_pkg.sv
package tepu_pkg;
   typedef enum {TEPU_PW_IDLE, TEPU_PW_ARMED, TEPU_PW_COUNT} tepu_pw_t;
   typedef struct packed {
      logic [1:0] mode;
      logic run;
      logic edgeSel;
      logic [2:0] divSel;
      logic resSel;
      logic pwm_output_enable;
   } tepu_ctrl_t;
endpackage

// ===== tepu_pulse_load.sv
`timescale 1ns/100ps
`default_nettype none
module tepu_pulse_load (
   input wire logic ref_clk,
   input wire logic [2:0] pwmChannelOut,
   input wire logic [2:0] pwmPinOe,
   output logic externalCountPin,
   output logic [2:0] loadLevel
);
   wire [2:0] pinNet;
   ////////////////////////////////////////////////////////////
   // Pulse source: the level holds until the bench asks for a change
   initial externalCountPin = 1'h0;
   task automatic drivePin(input logic v);
      externalCountPin <= v;
   endtask
   ////////////////////////////////////////////////////////////
   // Loads count only a driven 1 as high, so a released pin reads low, never stale
   for (genvar k = 0; k < 3; k++) begin : g_load
      assign pinNet[k] = pwmPinOe[k] ? pwmChannelOut[k] : 1'bz;
      assign loadLevel[k] = (pinNet[k] === 1'h1);
   end
endmodule
`default_nettype wire

// ===== tepu_timer8.sv
// Behaviour
// - PWM clock divided by 1,2,3,4,8,16,32,64
// - Resolution bit picks 6+2 or 7+1
// - Enable low forces channel outputs low
// - Enable low releases the output pins; the channel A twin output has no enable and stays driven high
// - First cycle after enable may deviate
// - Channel A has an inverted twin output
// - Duty writes act at once
// - Mode 10 counts prescaled clock falling edges
// - Timer overflow raises request and reloads
// - Timer keeps counting in low power states
// - Mode 01 counts count pin edges
// - Edge select picks rising or falling edge
// - Event counting wakes on overflow in sleep
// - Mode 11 waits for active edge first
// - Edge 0: low pulse, then run cleared
// - Edge 1: high pulse, then run cleared
// - After measurement pin edges are ignored
// - Overflow reloads preload in all count modes
// - Pulse width overflow wakes in sleep
// - Mode 00: 256-clock PWM cycle
// - 6+2: four 64-clock subcycles
// - Subcycle gets extra clock below extra count
// - 7+1: two 128-clock subcycles
// - Preload loads now if stopped else at overflow
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tepu_cfg.svh"
module tepu_timer8
   import tepu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic prescaledTimerClock,
   input wire logic externalCountPin,
   output logic [2:0] pwmChannelOut,
   output logic [2:0] pwmPinOe,
   output logic pwmAComplementOut,
   output logic timerIrq,
   output logic wakeReq
);
   //////////////////////////////////////////////////////////////////////
   // Registers and synchronisers
   tepu_ctrl_t ctrl_r;
   logic [7:0] preload_r;
   logic [7:0] count_r;
   logic [7:0] duty_r [3];
   logic [1:0] pinSync_r;
   logic [1:0] pscSync_r;
   logic pinPrev_r;
   logic pscPrev_r;
   logic ovfSticky_r;
   tepu_pw_t pwState_r;
   logic [5:0] divCnt_r;
   logic [7:0] pwmCnt_r;
   logic [2:0] chan_r;
   logic [3:0] awAddr_r;
   logic awHave_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wHave_r;

   // Divider terminal count for a select code
   function automatic logic [5:0] divTop(input logic [2:0] sel);
      case (sel)
         3'h0: divTop = 6'h00;
         3'h1: divTop = 6'h01;
         3'h2: divTop = 6'h02;
         3'h3: divTop = 6'h03;
         3'h4: divTop = 6'h07;
         3'h5: divTop = 6'h0f;
         3'h6: divTop = 6'h1f;
         default: divTop = 6'h3f;
      endcase
   endfunction

   // Subcycle high test for one channel
   function automatic logic pwmHigh(input logic [7:0] cnt,
         input logic [7:0] duty, input logic res);
      logic [7:0] coarse;
      logic [7:0] pos;
      logic extra;
      coarse = 8'h00;
      pos = 8'h00;
      extra = 1'b0;
      if (res) begin
         coarse = {1'b0, duty[7:1]};
         pos = {1'b0, cnt[6:0]};
         extra = ({7'h00, cnt[7]} < {7'h00, duty[0]});
      end else begin
         coarse = {2'h0, duty[7:2]};
         pos = {2'h0, cnt[5:0]};
         extra = ({6'h00, cnt[7:6]} < {6'h00, duty[1:0]});
      end
      pwmHigh = (pos < coarse) || ((pos == coarse) && extra);
   endfunction

   // Control byte to fields; bit 4 is run or divider msb by mode
   function automatic tepu_ctrl_t ctrlDecode(input logic [7:0] b);
      ctrlDecode = '{mode: b[`TEPU_MODE_HI:`TEPU_MODE_LO],
         run: b[`TEPU_RUN_BIT], edgeSel: b[`TEPU_EDGE_BIT],
         divSel: b[`TEPU_DIV_HI:`TEPU_DIV_LO], resSel: b[`TEPU_RES_BIT],
         pwm_output_enable: b[`TEPU_EN_BIT]};
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only stage two is read by logic
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pinSync_r <= 2'h0;
         pscSync_r <= 2'h0;
         pinPrev_r <= 1'b0;
         pscPrev_r <= 1'b0;
      end else begin
         pinSync_r <= {pinSync_r[0], externalCountPin};
         pscSync_r <= {pscSync_r[0], prescaledTimerClock};
         pinPrev_r <= pinSync_r[1];
         pscPrev_r <= pscSync_r[1];
      end
   end

   logic pinRise, pinFall, pscFall, activeEdge, endEdge;
   assign pinRise = pinSync_r[1] & ~pinPrev_r;
   assign pinFall = ~pinSync_r[1] & pinPrev_r;
   assign pscFall = ~pscSync_r[1] & pscPrev_r;
   // Edge select: 0 rising/low pulse start, 1 falling/high pulse
   assign activeEdge = ctrl_r.mode == `TEPU_MODE_EVT ?
      (ctrl_r.edgeSel ? pinFall : pinRise) :
      (ctrl_r.edgeSel ? pinRise : pinFall);
   assign endEdge = ctrl_r.edgeSel ? pinFall : pinRise;

   //////////////////////////////////////////////////////////////////////
   // Bus capture: address and data accepted in either order
   logic wrGo, rdGo;
   assign wrGo = awHave_r && wHave_r && !bvalid;
   assign rdGo = arvalid && arready;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         awHave_r <= 1'b0;
         awAddr_r <= 4'h0;
         awready <= 1'b1;
      end else if (awvalid && awready) begin
         awHave_r <= 1'b1;
         awAddr_r <= awaddr;
         awready <= 1'b0;
      end else if (wrGo) begin
         awHave_r <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wHave_r <= 1'b0;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         wready <= 1'b1;
      end else if (wvalid && wready) begin
         wHave_r <= 1'b1;
         wData_r <= wdata;
         wStrb_r <= wstrb;
         wready <= 1'b0;
      end else if (wrGo) begin
         wHave_r <= 1'b0;
         wready <= 1'b1;
      end
   end

   // Write response, unmapped address answers SLVERR
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `TEPU_RESP_OKAY;
      end else if (wrGo) begin
         bvalid <= 1'b1;
         bresp <= awAddr_r[1:0] != 2'h0 ? `TEPU_RESP_SLVERR
                                         : `TEPU_RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   logic wrOk, wrCtrl, wrCount;
   assign wrOk = wrGo && awAddr_r[1:0] == 2'h0 && wStrb_r[0];
   assign wrCtrl = wrOk && awAddr_r == `TEPU_ADDR_CTRL;
   assign wrCount = wrOk && awAddr_r == `TEPU_ADDR_COUNT;
   logic ovf, cntTick;
   assign ovf = ctrl_r.run && count_r == 8'hff && cntTick;

   //////////////////////////////////////////////////////////////////////
   // Count enable per mode
   always_comb begin
      case (ctrl_r.mode)
         `TEPU_MODE_TMR: cntTick = ctrl_r.run && pscFall;
         `TEPU_MODE_EVT: cntTick = ctrl_r.run && activeEdge;
         `TEPU_MODE_PWD: cntTick = pwState_r == TEPU_PW_COUNT &&
            pscFall && !endEdge;
         default: cntTick = 1'b0;
      endcase
   end

   // Control register; pulse-width end clears run
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_r <= ctrlDecode(`TEPU_CTRL_RST);
      end else if (wrCtrl) begin
         ctrl_r <= ctrlDecode(wData_r[7:0]);
      end else if (pwState_r == TEPU_PW_COUNT && endEdge) begin
         ctrl_r.run <= 1'b0;
      end
   end

   // Single-shot measurement sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pwState_r <= TEPU_PW_IDLE;
      end else begin
         case (pwState_r)
            TEPU_PW_IDLE: if (ctrl_r.run &&
               ctrl_r.mode == `TEPU_MODE_PWD) begin
               pwState_r <= TEPU_PW_ARMED;
            end
            TEPU_PW_ARMED: if (!ctrl_r.run ||
               ctrl_r.mode != `TEPU_MODE_PWD) begin
               pwState_r <= TEPU_PW_IDLE;
            end else if (activeEdge) begin
               pwState_r <= TEPU_PW_COUNT;
            end
            TEPU_PW_COUNT: if (endEdge || !ctrl_r.run ||
               ctrl_r.mode != `TEPU_MODE_PWD) begin
               pwState_r <= TEPU_PW_IDLE;
            end
            default: pwState_r <= TEPU_PW_IDLE;
         endcase
      end
   end

   // Preload and counter; run low means direct load
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         preload_r <= 8'h00;
         count_r <= 8'h00;
      end else begin
         if (wrCount) begin
            preload_r <= wData_r[7:0];
         end
         if (wrCount && !ctrl_r.run) begin
            count_r <= wData_r[7:0];
         end else if (ovf) begin
            count_r <= preload_r;
         end else if (cntTick) begin
            count_r <= count_r + 8'h01;
         end
      end
   end

   // Overflow request pulse; sticky copy for software, set wins
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timerIrq <= 1'b0;
         wakeReq <= 1'b0;
         ovfSticky_r <= 1'b0;
      end else begin
         timerIrq <= ovf;
         wakeReq <= ovf && ctrl_r.mode != `TEPU_MODE_TMR;
         if (ovf) begin
            ovfSticky_r <= 1'b1;
         end else if (wrCtrl && wData_r[`TEPU_OVF_BIT]) begin
            ovfSticky_r <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Duty registers; channel A shares the count address
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         duty_r[0] <= `TEPU_DUTY_RST;
         duty_r[1] <= `TEPU_DUTY_RST;
         duty_r[2] <= `TEPU_DUTY_RST;
      end else begin
         if (wrCount) duty_r[0] <= wData_r[7:0];
         if (wrOk && awAddr_r == `TEPU_ADDR_DUTYB) duty_r[1] <= wData_r[7:0];
         if (wrOk && awAddr_r == `TEPU_ADDR_DUTYC) duty_r[2] <= wData_r[7:0];
      end
   end

   logic pwmOn, divTick;
   assign pwmOn = ctrl_r.mode == `TEPU_MODE_PWM && ctrl_r.pwm_output_enable;
   assign divTick = divCnt_r >= divTop(ctrl_r.divSel);

   // Shared divider and 256-clock counter; restart on enable
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !pwmOn) begin
         divCnt_r <= 6'h00;
         pwmCnt_r <= 8'h00;
      end else if (divTick) begin
         divCnt_r <= 6'h00;
         pwmCnt_r <= pwmCnt_r + 8'h01;
      end else begin
         divCnt_r <= divCnt_r + 6'h01;
      end
   end

   // Channel compare; duty read live so writes act at once
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_chan
         always_ff @(posedge ref_clk) begin
            if (!rst_n || !pwmOn) begin
               chan_r[gi] <= 1'b0;
            end else begin
               chan_r[gi] <= pwmHigh(pwmCnt_r, duty_r[gi],
                  ctrl_r.resSel);
            end
         end
      end
   endgenerate

   // Pin drivers; enables drop so channel pins float when disabled, twin driven high
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pwmChannelOut <= 3'h0;
         pwmPinOe <= 3'h0;
         pwmAComplementOut <= 1'b1;
      end else begin
         pwmChannelOut <= chan_r;
         pwmPinOe <= {3{pwmOn}};
         pwmAComplementOut <= ~chan_r[0];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Read channel, one cycle latency
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `TEPU_RESP_OKAY;
      end else if (rdGo) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= araddr[1:0] != 2'h0 ? `TEPU_RESP_SLVERR
                                       : `TEPU_RESP_OKAY;
         case (araddr)
            `TEPU_ADDR_CTRL: rdata <= {22'h0, wakeReq, ovfSticky_r,
               ctrl_r.mode, 1'b0, ctrl_r.mode == `TEPU_MODE_PWM ?
               {ctrl_r.divSel, ctrl_r.resSel, ctrl_r.pwm_output_enable} :
               {ctrl_r.run, ctrl_r.edgeSel, ctrl_r.divSel[0],
               ctrl_r.resSel, ctrl_r.pwm_output_enable}};
            `TEPU_ADDR_COUNT: rdata <= {24'h0, ctrl_r.mode ==
               `TEPU_MODE_PWM ? duty_r[0] : count_r};
            `TEPU_ADDR_DUTYB: rdata <= {24'h0, duty_r[1]};
            `TEPU_ADDR_DUTYC: rdata <= {24'h0, duty_r[2]};
            default: rdata <= 32'h0;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Assertions
   property pwOffP;
      @(posedge ref_clk) disable iff (!rst_n)
      !pwmOn |=> (pwmPinOe == 3'h0) ##1 (pwmChannelOut == 3'h0);
   endproperty
   chan_low_a: assert property (pwOffP) else $error("pwm not low");
   comp_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pwmAComplementOut == ~pwmChannelOut[0]) else $error("no pair");
   sequence ovfSeq;
      ctrl_r.run && count_r == 8'hff && cntTick;
   endsequence
   reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ovfSeq and !wrCount |=> count_r == $past(preload_r))
      else $error("no reload");
   irq_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ovfSeq |=> timerIrq) else $error("irq missing");
   stop_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrCount && !ctrl_r.run |=> count_r == $past(wData_r[7:0]))
      else $error("no direct load");
   pw_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pwState_r == TEPU_PW_COUNT && endEdge && !wrCtrl |=> !ctrl_r.run)
      else $error("run not cleared");
   pw_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pwState_r == TEPU_PW_ARMED && !wrCount |=> $stable(count_r))
      else $error("counted early");
   div_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      divCnt_r <= divTop(ctrl_r.divSel) || $changed(ctrl_r.divSel)
      || !$past(pwmOn)) else $error("divider overrun");
endmodule
`default_nettype wire

// ===== timer8_event_pwm_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tepu_cfg.svh"
module timer8_event_pwm_unit_bench;
   logic ref_clk = 1'h0, rst_n = 1'h0, psClk = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, countPin;
   logic pwmAComplementOut, timerIrq, wakeReq;
   logic [1:0] bresp, rresp;
   logic [2:0] pwmChannelOut, pwmPinOe, loadLevel;
   int error_cnt = 0, checked = 0, irqN = 0, wakeN = 0;
   int divs[8] = '{1, 2, 3, 4, 8, 16, 32, 64};

   tepu_timer8 tepu_timer8_inst (.ref_clk, .rst_n, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .prescaledTimerClock(psClk), .externalCountPin(countPin),
      .pwmChannelOut, .pwmPinOe, .pwmAComplementOut, .timerIrq, .wakeReq);
   tepu_pulse_load tepu_pulse_load_inst (.ref_clk, .pwmChannelOut,
      .pwmPinOe, .externalCountPin(countPin), .loadLevel);

   // 10 MHz system clock
   always #50 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   // Verdict, comparison and bounded waits
   task automatic end_of_test();
      if (error_cnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic guard(inout int n);
      n++;
      if (n > 500) begin
         error_cnt++;
         end_of_test();
      end
   endtask
   // Clock steps that also tally the one-cycle overflow pulses
   task automatic run(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         irqN += int'(timerIrq === 1'h1);
         wakeN += int'(wakeReq === 1'h1);
      end
   endtask
   task automatic pin(input logic v);
      tepu_pulse_load_inst.drivePin(v);
   endtask
   // Slow enough that the two-stage input sync never misses a fall
   task automatic psFall(input int n);
      repeat (n) begin
         psClk <= 1'h1;
         run(4);
         psClk <= 1'h0;
         run(4);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Bus master: each channel held until its own ready is sampled
   task automatic axiWr(input logic [3:0] a, input logic [7:0] d,
         input logic [1:0] er = `TEPU_RESP_OKAY);
      int n = 0;
      logic done = 1'h0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done) begin
         run(1);
         guard(n);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            done = 1'h1;
            bready <= 1'h0;
            chk(bresp, er);
         end
      end
      // Idle edge so a following call never re-raises bready at once
      run(1);
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hffffffff);
      int n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         run(1);
         guard(n);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk(rresp, `TEPU_RESP_OKAY);
      chk(rdata & m, e);
      run(1);
   endtask
   ////////////////////////////////////////////////////////////
   // Reset values and a misaligned write that must change nothing
   task automatic regScen();
      rdChk(`TEPU_ADDR_CTRL, 32'h0);
      rdChk(`TEPU_ADDR_DUTYB, 32'h0);
      rdChk(`TEPU_ADDR_DUTYC, 32'h0);
      axiWr(4'h9, 8'h5a, `TEPU_RESP_SLVERR);
      rdChk(`TEPU_ADDR_DUTYB, 32'h0);
      chk(pwmPinOe, 3'h0);
   endtask
   // First cycle skipped, then one whole cycle measured at the loads
   task automatic pwmScen(input logic [7:0] ctl, input int dv,
         input logic [7:0] da, input logic [7:0] db);
      int h[3] = '{0, 0, 0};
      int bad = 0;
      axiWr(`TEPU_ADDR_COUNT, da);
      axiWr(`TEPU_ADDR_DUTYB, db);
      axiWr(`TEPU_ADDR_DUTYC, 8'hff);
      axiWr(`TEPU_ADDR_CTRL, ctl);
      run(256 * dv + 4);
      for (int i = 0; i < 256 * dv; i++) begin
         run(1);
         for (int k = 0; k < 3; k++) h[k] += int'(loadLevel[k]);
         bad += int'(pwmAComplementOut === pwmChannelOut[0]);
         if (i == 63 && dv == 1 && !ctl[1])
            chk(h[0] == da[7:2] || h[0] == da[7:2] + 1, 1);
      end
      chk(h[0], da * dv);
      chk(h[1], db * dv);
      chk(h[2], 255 * dv);
      chk(bad, 0);
   endtask
   task automatic offScen();
      axiWr(`TEPU_ADDR_CTRL, 8'h02);
      run(4);
      chk(pwmChannelOut, 3'h0);
      chk(pwmPinOe, 3'h0);
      chk(pwmAComplementOut, 1'h1);
   endtask
   task automatic tmrScen();
      axiWr(`TEPU_ADDR_CTRL, 8'h80);
      axiWr(`TEPU_ADDR_COUNT, 8'hfd);
      psFall(1);
      rdChk(`TEPU_ADDR_COUNT, 32'hfd);
      axiWr(`TEPU_ADDR_CTRL, 8'h90);
      irqN = 0;
      psFall(3);
      chk(irqN, 1);
      rdChk(`TEPU_ADDR_COUNT, 32'hfd);
      axiWr(`TEPU_ADDR_COUNT, 8'h10);
      rdChk(`TEPU_ADDR_COUNT, 32'hfd);
      psFall(3);
      rdChk(`TEPU_ADDR_COUNT, 32'h10);
      chk(irqN, 2);
   endtask
   task automatic evtScen(input logic e);
      axiWr(`TEPU_ADDR_CTRL, {4'h4, e, 3'h0});
      axiWr(`TEPU_ADDR_COUNT, 8'hfe);
      axiWr(`TEPU_ADDR_CTRL, {4'h5, e, 3'h0});
      pin(1'h1);
      run(8);
      rdChk(`TEPU_ADDR_COUNT, e ? 32'hfe : 32'hff);
      pin(1'h0);
      run(8);
      rdChk(`TEPU_ADDR_COUNT, 32'hff);
      irqN = 0;
      wakeN = 0;
      pin(1'h1);
      run(8);
      pin(1'h0);
      run(8);
      chk(irqN, 1);
      chk(wakeN, 1);
      rdChk(`TEPU_ADDR_COUNT, 32'hfe);
   endtask
   // Low pulse of five ticks, then a second pulse that must be ignored
   task automatic pwScen();
      pin(1'h1);
      axiWr(`TEPU_ADDR_CTRL, 8'hc0);
      axiWr(`TEPU_ADDR_COUNT, 8'h00);
      axiWr(`TEPU_ADDR_CTRL, 8'hd0);
      run(8);
      psFall(2);
      rdChk(`TEPU_ADDR_COUNT, 32'h0);
      pin(1'h0);
      run(8);
      psFall(5);
      pin(1'h1);
      run(8);
      psFall(2);
      rdChk(`TEPU_ADDR_CTRL, 32'hc0, 32'hff);
      pin(1'h0);
      run(8);
      psFall(2);
      pin(1'h1);
      run(8);
      rdChk(`TEPU_ADDR_COUNT, 32'h5);
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence: every divider code, both resolutions alternating
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'h1;
      run(3);
      regScen();
      for (int d = 0; d < 8; d++)
         pwmScen({3'h0, d[2:0], d[0], 1'h1}, divs[d], 8'h81 + 8'(d),
            8'h3e - 8'(d));
      offScen();
      tmrScen();
      evtScen(1'h0);
      evtScen(1'h1);
      pwScen();
      end_of_test();
   end
endmodule
`default_nettype wire
